// *** hw/s3rc_bank.sv ***
/*
 * s3rc_bank: third stimulus/response configuration register bank with its
 * decoded line controls, pull-down current, threshold and divider ratio.
 * Assumes a plain register port (read data one cycle after the strobe) and
 * that trigger select, prior-response flags and legacy profile state come
 * from neighbouring sequencer logic, synchronous to sys_clk.
 */
// Our own choice: the address-and-strobe port.
// Functional notes
// R01: writes carrying a reserved code leave that field at its previous value.
// R02: voltage responses: magnitude gives pull-down or 400 to 2200 mV; 1111 reserved.
// R03: resistor-to-ground responses: magnitude gives 1.8 k to 150 k; 1111 reserved.
// R04: divider responses: magnitude gives minimum divider total 93 k to 200 k.
// R05: select 0000 removes, 0001/0010/0011 apply voltage; 0101,1000,1011 reserved.
// R06: codes 0100,0111,1101 resistor to ground; 1010 bridge resistor between lines.
// R07: codes 0110,1001,1100 connect VBUS divider tapped on plus, minus, both.
// R08: codes 1110/1111 keep pull-downs on trigger 000, drop on 111, else hold.
// R09: single-line response keeps that line's pull-down only on trigger 000 when free.
// R10: voltage response at magnitude 0000 uses pull-down current 10/50/100/150 uA.
// R11: threshold 300 to 2200 mV, 1111 reserved, ignored on trigger 000 or 111.
// R12: pull-down current and threshold frozen and disregarded while a legacy profile runs.
// R13: unimplemented bits read zero and ignore writes.
`timescale 1ns/1ps
module s3rc_bank (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [s3rc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [s3rc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [s3rc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [2:0] third_trigger_select,
    input wire logic [1:0] prior_response_present,
    input wire logic legacy_profile_active,
    output s3rc_pkg::s3rc_line_type downstream_plus_line,
    output s3rc_pkg::s3rc_line_type downstream_minus_line,
    output s3rc_pkg::s3rc_pulldown_type plus_reset_pulldown,
    output s3rc_pkg::s3rc_pulldown_type minus_reset_pulldown,
    output logic [11:0] response_level,
    output logic [7:0] third_pulldown_current,
    output logic pulldown_current_valid,
    output logic [11:0] third_detect_threshold,
    output logic threshold_valid,
    output logic [2:0] third_divider_ratio
);
    import s3rc_pkg::*;

    logic [7:0] response_reg;
    logic [7:0] threshold_reg;
    logic [7:0] divider_reg;
    logic [7:0] response_next;
    logic [7:0] threshold_next;
    logic [7:0] divider_next;
    logic [7:0] rdata_next;
    logic pulldown_use;
    logic threshold_use;

    s3rc_decode_if dec_bus ();

    s3rc_write_guard u_guard (
        .reg_write(reg_write),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .response_reg(response_reg),
        .threshold_reg(threshold_reg),
        .divider_reg(divider_reg),
        .response_next(response_next),
        .threshold_next(threshold_next),
        .divider_next(divider_next)
    );

    s3rc_response_decode u_decode (
        .dec(dec_bus.decoder)
    );

    assign dec_bus.select = response_reg[SEL_LSB +: 4];
    assign dec_bus.magnitude = response_reg[MAG_LSB +: 4];
    assign dec_bus.trigger = third_trigger_select;
    assign dec_bus.prior = prior_response_present;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            response_reg <= RESPONSE_RESET;
            threshold_reg <= THRESHOLD_RESET;
            divider_reg <= DIVIDER_RESET;
        end else begin
            response_reg <= response_next; // R01
            threshold_reg <= threshold_next; // R01 R13
            divider_reg <= divider_next; // R01 R13
        end
    end

    always_comb begin
        rdata_next = READ_IDLE;
        if (reg_read) begin
            case (reg_addr)
                RESPONSE_ADDR: rdata_next = response_reg & RESPONSE_MASK;
                THRESHOLD_ADDR: rdata_next = threshold_reg & THRESHOLD_MASK; // R13
                DIVIDER_ADDR: rdata_next = divider_reg & DIVIDER_MASK; // R13
                default: rdata_next = READ_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= READ_IDLE;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

    // line controls follow the stored setup one cycle later
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            downstream_plus_line <= LR_HOLD;
            downstream_minus_line <= LR_HOLD;
            plus_reset_pulldown <= PD_HOLD;
            minus_reset_pulldown <= PD_HOLD;
            response_level <= 12'h000;
            third_divider_ratio <= DIVIDER_RESET[2:0];
        end else begin
            downstream_plus_line <= dec_bus.plus_line; // R05 R06 R07
            downstream_minus_line <= dec_bus.minus_line; // R05 R06 R07
            plus_reset_pulldown <= dec_bus.plus_pd; // R08 R09
            minus_reset_pulldown <= dec_bus.minus_pd; // R08 R09
            response_level <= dec_bus.level; // R02 R03 R04
            third_divider_ratio <= divider_reg[RATIO_LSB +: 3];
        end
    end

    assign pulldown_use = dec_bus.select <= SEL_V_BOTH && dec_bus.select != SEL_REMOVE
                          && dec_bus.magnitude == MAG_PULLDOWN;
    assign threshold_use = third_trigger_select != TRIG_VBUS_READY && third_trigger_select != TRIG_VBUS_PRESENT;

    // profile-gated settings: frozen while a legacy profile runs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            third_pulldown_current <= current_ua(THRESHOLD_RESET[PUPD_LSB +: 2]);
            third_detect_threshold <= threshold_mv(THRESHOLD_RESET[TH_LSB +: 4]);
            pulldown_current_valid <= 1'b0;
            threshold_valid <= 1'b0;
        end else if (legacy_profile_active) begin // R12
            pulldown_current_valid <= 1'b0;
            threshold_valid <= 1'b0;
        end else begin
            third_pulldown_current <= current_ua(threshold_reg[PUPD_LSB +: 2]); // R10
            third_detect_threshold <= threshold_mv(threshold_reg[TH_LSB +: 4]); // R11
            pulldown_current_valid <= pulldown_use; // R10
            threshold_valid <= threshold_use; // R11
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_reserved_mag_kept: assert property ( // R01
        reg_write && reg_addr == RESPONSE_ADDR && reg_wdata[7:4] == MAG_RESERVED
        |=> response_reg[7:4] == $past(response_reg[7:4]))
        else $error("reserved magnitude was stored");
    a_reserved_sel_kept: assert property ( // R05
        reg_write && reg_addr == RESPONSE_ADDR
        && (reg_wdata[3:0] == SEL_RSV_A || reg_wdata[3:0] == SEL_RSV_B || reg_wdata[3:0] == SEL_RSV_C)
        |=> response_reg[3:0] == $past(response_reg[3:0]))
        else $error("reserved response select was stored");
    a_good_write_taken: assert property ( // R01
        reg_write && reg_addr == DIVIDER_ADDR && reg_wdata[2:0] != RATIO_RESERVED
        |=> divider_reg == {5'h00, $past(reg_wdata[2:0])} ##1 third_divider_ratio == $past(divider_reg[2:0]))
        else $error("valid ratio write not taken");
    a_reserved_th_kept: assert property ( // R11
        reg_write && reg_addr == THRESHOLD_ADDR && reg_wdata[3:0] == TH_RESERVED
        |=> threshold_reg[3:0] == $past(threshold_reg[3:0]))
        else $error("reserved threshold was stored");
    a_unimpl_read_zero: assert property ( // R13
        reg_read && reg_addr == THRESHOLD_ADDR |=> reg_rdata[7:6] == 2'b00)
        else $error("unimplemented threshold bits read nonzero");
    a_voltage_level: assert property ( // R02
        response_reg == 8'h51 |=> downstream_plus_line == LR_VOLTAGE
        && downstream_minus_line == LR_HOLD && response_level == 12'h1F4)
        else $error("voltage response decode wrong");
    a_bridge_both: assert property ( // R06
        response_reg[3:0] == SEL_BRIDGE |=> downstream_plus_line == LR_BRIDGE && downstream_minus_line == LR_BRIDGE)
        else $error("bridge response decode wrong");
    a_divider_both: assert property ( // R07
        response_reg[3:0] == SEL_DIV_BOTH && response_reg[6:4] == 3'h0
        |=> downstream_plus_line == LR_DIVIDER && downstream_minus_line == LR_DIVIDER && response_level == 12'h3A2)
        else $error("divider response decode wrong");
    a_pd_ctrl_keep: assert property ( // R08
        response_reg[3:1] == 3'b111 && third_trigger_select == TRIG_VBUS_READY
        |=> plus_reset_pulldown == PD_KEEP && minus_reset_pulldown == PD_KEEP)
        else $error("pull-downs not kept on ready trigger");
    a_single_line_pd: assert property ( // R09
        response_reg[3:0] == SEL_V_PLUS && third_trigger_select == TRIG_VBUS_READY && !prior_response_present[0]
        |=> plus_reset_pulldown == PD_KEEP && minus_reset_pulldown == PD_HOLD)
        else $error("single-line pull-down decision wrong");
    a_current_decode: assert property ( // R10
        !legacy_profile_active && threshold_reg[5:4] == 2'b11 |=> third_pulldown_current == 8'h96)
        else $error("pull-down current decode wrong");
    a_threshold_ignore: assert property ( // R11
        third_trigger_select == TRIG_VBUS_PRESENT |=> !threshold_valid)
        else $error("threshold used on power trigger");
    a_legacy_freeze: assert property ( // R12
        legacy_profile_active [*2] |-> $stable(third_detect_threshold) && $stable(third_pulldown_current)
        && !threshold_valid)
        else $error("gated settings changed under legacy profile");

    c_reserved_write: cover property (reg_write && reg_addr == RESPONSE_ADDR && reg_wdata[7:4] == MAG_RESERVED);
    c_divider_tap: cover property (downstream_plus_line == LR_DIVIDER && downstream_minus_line == LR_DIVIDER);
    c_pd_drop: cover property (plus_reset_pulldown == PD_DROP && minus_reset_pulldown == PD_DROP);
    c_legacy_gate: cover property (legacy_profile_active ##1 !legacy_profile_active ##1 threshold_valid);

endmodule

// *** hw/s3rc_decode_if.sv ***
/*
 * s3rc_decode_if: carries the stored response setup to the decoder
 * and its per-line result back to the register bank.
 * Assumes both ends sit in the sys_clk domain.
 */
`timescale 1ns/1ps
interface s3rc_decode_if;
    import s3rc_pkg::*;
    logic [3:0] select;
    logic [3:0] magnitude;
    logic [2:0] trigger;
    logic [1:0] prior;
    s3rc_line_type plus_line;
    s3rc_line_type minus_line;
    s3rc_pulldown_type plus_pd;
    s3rc_pulldown_type minus_pd;
    logic [11:0] level;

    modport bank (output select, magnitude, trigger, prior,
                  input plus_line, minus_line, plus_pd, minus_pd, level);
    modport decoder (input select, magnitude, trigger, prior,
                     output plus_line, minus_line, plus_pd, minus_pd, level);
endinterface

// *** hw/s3rc_pkg.sv ***
/*
 * s3rc_pkg: addresses, field layouts, codes and decode tables of the
 * third stimulus/response configuration registers.
 * Assumes an 8-bit register port and a 20 MHz system clock.
 */
package s3rc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    localparam logic [7:0] RESPONSE_ADDR = 8'h4A;
    localparam logic [7:0] THRESHOLD_ADDR = 8'h4B;
    localparam logic [7:0] DIVIDER_ADDR = 8'h4C;

    localparam logic [7:0] RESPONSE_RESET = 8'h00;
    localparam logic [7:0] THRESHOLD_RESET = 8'h00;
    localparam logic [7:0] DIVIDER_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // implemented bits of each register
    localparam logic [7:0] RESPONSE_MASK = 8'hFF;
    localparam logic [7:0] THRESHOLD_MASK = 8'h3F;
    localparam logic [7:0] DIVIDER_MASK = 8'h07;

    localparam int SEL_LSB = 0;
    localparam int MAG_LSB = 4;
    localparam int TH_LSB = 0;
    localparam int PUPD_LSB = 4;
    localparam int RATIO_LSB = 0;

    localparam logic [3:0] SEL_REMOVE = 4'h0;
    localparam logic [3:0] SEL_V_PLUS = 4'h1;
    localparam logic [3:0] SEL_V_MINUS = 4'h2;
    localparam logic [3:0] SEL_V_BOTH = 4'h3;
    localparam logic [3:0] SEL_R_PLUS = 4'h4;
    localparam logic [3:0] SEL_RSV_A = 4'h5;
    localparam logic [3:0] SEL_DIV_PLUS = 4'h6;
    localparam logic [3:0] SEL_R_MINUS = 4'h7;
    localparam logic [3:0] SEL_RSV_B = 4'h8;
    localparam logic [3:0] SEL_DIV_MINUS = 4'h9;
    localparam logic [3:0] SEL_BRIDGE = 4'hA;
    localparam logic [3:0] SEL_RSV_C = 4'hB;
    localparam logic [3:0] SEL_DIV_BOTH = 4'hC;
    localparam logic [3:0] SEL_R_BOTH = 4'hD;
    localparam logic [3:0] SEL_PD_CTRL_A = 4'hE;
    localparam logic [3:0] SEL_PD_CTRL_B = 4'hF;

    localparam logic [3:0] MAG_RESERVED = 4'hF;
    localparam logic [3:0] MAG_PULLDOWN = 4'h0;
    localparam logic [3:0] TH_RESERVED = 4'hF;
    localparam logic [2:0] RATIO_RESERVED = 3'h7;

    localparam logic [2:0] TRIG_VBUS_READY = 3'h0;
    localparam logic [2:0] TRIG_VBUS_PRESENT = 3'h7;

    typedef enum logic [5:0] {
        LR_HOLD = 6'b00_0001,
        LR_REMOVE = 6'b00_0010,
        LR_VOLTAGE = 6'b00_0100,
        LR_RES_GND = 6'b00_1000,
        LR_DIVIDER = 6'b01_0000,
        LR_BRIDGE = 6'b10_0000
    } s3rc_line_type;

    typedef enum logic [2:0] {
        PD_HOLD = 3'b001,
        PD_KEEP = 3'b010,
        PD_DROP = 3'b100
    } s3rc_pulldown_type;

    // applied voltage in mV
    function automatic logic [11:0] voltage_mv(input logic [3:0] code);
        case (code)
            4'h1, 4'h2, 4'h3, 4'h4: voltage_mv = 12'h190;
            4'h5: voltage_mv = 12'h1F4;
            4'h6: voltage_mv = 12'h258;
            4'h7: voltage_mv = 12'h2BC;
            4'h8: voltage_mv = 12'h320;
            4'h9: voltage_mv = 12'h384;
            4'hA: voltage_mv = 12'h578;
            4'hB: voltage_mv = 12'h640;
            4'hC: voltage_mv = 12'h708;
            4'hD: voltage_mv = 12'h7D0;
            4'hE: voltage_mv = 12'h898;
            default: voltage_mv = 12'h000;
        endcase
    endfunction

    // detection threshold in mV
    function automatic logic [11:0] threshold_mv(input logic [3:0] code);
        case (code)
            4'h0, 4'h1, 4'h2: threshold_mv = 12'h190;
            4'h3: threshold_mv = 12'h12C;
            default: threshold_mv = voltage_mv(code);
        endcase
    endfunction

    // resistor to ground in units of 100 ohm
    function automatic logic [11:0] resistor_hecto(input logic [3:0] code);
        case (code)
            4'h0: resistor_hecto = 12'h012;
            4'h1: resistor_hecto = 12'h064;
            4'h2: resistor_hecto = 12'h096;
            4'h3: resistor_hecto = 12'h0C8;
            4'h4: resistor_hecto = 12'h0FA;
            4'h5: resistor_hecto = 12'h12C;
            4'h6: resistor_hecto = 12'h190;
            4'h7: resistor_hecto = 12'h1AE;
            4'h8: resistor_hecto = 12'h1F4;
            4'h9: resistor_hecto = 12'h258;
            4'hA: resistor_hecto = 12'h2EE;
            4'hB: resistor_hecto = 12'h320;
            4'hC: resistor_hecto = 12'h3E8;
            4'hD: resistor_hecto = 12'h4B0;
            4'hE: resistor_hecto = 12'h5DC;
            default: resistor_hecto = 12'h000;
        endcase
    endfunction

    // minimum divider total in units of 100 ohm
    function automatic logic [11:0] divider_hecto(input logic [3:0] code);
        if (code == MAG_RESERVED) begin
            divider_hecto = 12'h000;
        end else if (code[2]) begin
            divider_hecto = 12'h7D0;
        end else begin
            case (code[1:0])
                2'h0: divider_hecto = 12'h3A2;
                2'h1: divider_hecto = 12'h3E8;
                2'h2: divider_hecto = 12'h4E2;
                default: divider_hecto = 12'h5DC;
            endcase
        end
    endfunction

    // pull-down current in uA
    function automatic logic [7:0] current_ua(input logic [1:0] code);
        case (code)
            2'h0: current_ua = 8'h0A;
            2'h1: current_ua = 8'h32;
            2'h2: current_ua = 8'h64;
            default: current_ua = 8'h96;
        endcase
    endfunction

endpackage

// *** hw/s3rc_response_decode.sv ***
/*
 * s3rc_response_decode: turns the response select, magnitude and trigger
 * into an action and reset pull-down decision for each data line.
 * Assumes reserved codes never reach it (the write guard refuses them).
 */
`timescale 1ns/1ps
module s3rc_response_decode (
    s3rc_decode_if.decoder dec
);
    import s3rc_pkg::*;

    s3rc_line_type kind;
    logic hit_plus;
    logic hit_minus;
    logic pd_ctrl;

    // single-line rule: keep the reset pull-down only on a ready trigger with nothing else on the line
    function automatic s3rc_pulldown_type line_pd(input logic [2:0] trig, input logic prior);
        if (trig == TRIG_VBUS_READY && !prior) begin
            line_pd = PD_KEEP;
        end else if (prior) begin
            line_pd = PD_HOLD;
        end else begin
            line_pd = PD_DROP;
        end
    endfunction

    always_comb begin
        kind = LR_HOLD;
        hit_plus = 1'b0;
        hit_minus = 1'b0;
        pd_ctrl = 1'b0;
        case (dec.select)
            SEL_REMOVE: begin // R05
                kind = LR_REMOVE;
                hit_plus = 1'b1;
                hit_minus = 1'b1;
            end
            SEL_V_PLUS, SEL_V_MINUS, SEL_V_BOTH: begin // R05
                kind = LR_VOLTAGE;
                hit_plus = dec.select[0];
                hit_minus = dec.select[1];
            end
            SEL_R_PLUS, SEL_R_MINUS, SEL_R_BOTH: begin // R06
                kind = LR_RES_GND;
                hit_plus = dec.select != SEL_R_MINUS;
                hit_minus = dec.select != SEL_R_PLUS;
            end
            SEL_DIV_PLUS, SEL_DIV_MINUS, SEL_DIV_BOTH: begin // R07
                kind = LR_DIVIDER;
                hit_plus = dec.select != SEL_DIV_MINUS;
                hit_minus = dec.select != SEL_DIV_PLUS;
            end
            SEL_BRIDGE: begin // R06
                kind = LR_BRIDGE;
                hit_plus = 1'b1;
                hit_minus = 1'b1;
            end
            SEL_PD_CTRL_A, SEL_PD_CTRL_B: begin // R08
                pd_ctrl = 1'b1;
            end
            default: begin
                kind = LR_HOLD;
            end
        endcase
    end

    always_comb begin
        dec.plus_line = hit_plus ? kind : LR_HOLD;
        dec.minus_line = hit_minus ? kind : LR_HOLD;
        dec.plus_pd = PD_HOLD;
        dec.minus_pd = PD_HOLD;
        if (pd_ctrl) begin // R08
            if (dec.trigger == TRIG_VBUS_READY) begin
                dec.plus_pd = PD_KEEP;
                dec.minus_pd = PD_KEEP;
            end else if (dec.trigger == TRIG_VBUS_PRESENT) begin
                dec.plus_pd = PD_DROP;
                dec.minus_pd = PD_DROP;
            end
        end else if (kind != LR_REMOVE) begin // R09
            if (hit_plus) begin
                dec.plus_pd = line_pd(dec.trigger, dec.prior[0]);
            end
            if (hit_minus) begin
                dec.minus_pd = line_pd(dec.trigger, dec.prior[1]);
            end
        end
    end

    always_comb begin
        case (kind)
            LR_VOLTAGE: dec.level = voltage_mv(dec.magnitude); // R02
            LR_RES_GND: dec.level = resistor_hecto(dec.magnitude); // R03
            LR_DIVIDER: dec.level = divider_hecto(dec.magnitude); // R04
            default: dec.level = 12'h000;
        endcase
    end

endmodule

// *** hw/s3rc_write_guard.sv ***
/*
 * s3rc_write_guard: forms the next value of each register on a write,
 * refusing each field separately when it carries a reserved code.
 * Assumes one-cycle write strobes on the register port.
 */
`timescale 1ns/1ps
module s3rc_write_guard (
    input wire logic reg_write,
    input wire logic [s3rc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [s3rc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [7:0] response_reg,
    input wire logic [7:0] threshold_reg,
    input wire logic [7:0] divider_reg,
    output logic [7:0] response_next,
    output logic [7:0] threshold_next,
    output logic [7:0] divider_next
);
    import s3rc_pkg::*;

    logic [3:0] new_mag;
    logic [3:0] new_sel;
    logic [3:0] new_th;
    logic [1:0] new_pupd;
    logic [2:0] new_ratio;

    assign new_mag = reg_wdata[MAG_LSB +: 4];
    assign new_sel = reg_wdata[SEL_LSB +: 4];
    assign new_th = reg_wdata[TH_LSB +: 4];
    assign new_pupd = reg_wdata[PUPD_LSB +: 2];
    assign new_ratio = reg_wdata[RATIO_LSB +: 3];

    always_comb begin
        response_next = response_reg;
        threshold_next = threshold_reg;
        divider_next = divider_reg;
        if (reg_write && reg_addr == RESPONSE_ADDR) begin
            if (new_mag != MAG_RESERVED) begin // R01 R02 R03 R04
                response_next[MAG_LSB +: 4] = new_mag;
            end
            if (new_sel != SEL_RSV_A && new_sel != SEL_RSV_B && new_sel != SEL_RSV_C) begin // R01 R05
                response_next[SEL_LSB +: 4] = new_sel;
            end
        end
        if (reg_write && reg_addr == THRESHOLD_ADDR) begin
            threshold_next[PUPD_LSB +: 2] = new_pupd;
            if (new_th != TH_RESERVED) begin // R01 R11
                threshold_next[TH_LSB +: 4] = new_th;
            end
        end
        if (reg_write && reg_addr == DIVIDER_ADDR && new_ratio != RATIO_RESERVED) begin // R01
            divider_next[RATIO_LSB +: 3] = new_ratio;
        end
        threshold_next = threshold_next & THRESHOLD_MASK; // R13
        divider_next = divider_next & DIVIDER_MASK; // R13
    end

endmodule

// *** tb/test_stimulus3_response_config.sv ***
/*
 * test bench for s3rc_bank: register port, response decode, gated outputs.
 * assumes the s3rc_pkg package and a 20 MHz sys_clk; drives every port itself.
 */
`timescale 1ns/1ps
module test_stimulus3_response_config;
    import s3rc_pkg::*;
    typedef struct {logic [7:0] wd, rd; s3rc_line_type p, m; logic [11:0] lv;} s3rc_row_type;
    logic sys_clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, legacy = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata, cur, v;
    logic [2:0] trig = 3'h1, ratio;
    logic [1:0] prior = 2'h0;
    logic [11:0] lvl, thr;
    logic cval, tval;
    s3rc_line_type pl, ml;
    s3rc_pulldown_type ppd, mpd;
    int fails = 0, checked = 0;
    s3rc_row_type rows [15] = '{
        '{8'h51, 8'h51, LR_VOLTAGE, LR_HOLD, 12'h1F4}, '{8'h02, 8'h02, LR_HOLD, LR_VOLTAGE, 12'h000},
        '{8'hE3, 8'hE3, LR_VOLTAGE, LR_VOLTAGE, 12'h898}, '{8'hF4, 8'hE4, LR_RES_GND, LR_HOLD, 12'h5DC},
        '{8'h15, 8'h14, LR_RES_GND, LR_HOLD, 12'h064}, '{8'h08, 8'h04, LR_RES_GND, LR_HOLD, 12'h012},
        '{8'hFB, 8'h04, LR_RES_GND, LR_HOLD, 12'h012}, '{8'h07, 8'h07, LR_HOLD, LR_RES_GND, 12'h012},
        '{8'h46, 8'h46, LR_DIVIDER, LR_HOLD, 12'h7D0}, '{8'hB9, 8'hB9, LR_HOLD, LR_DIVIDER, 12'h5DC},
        '{8'h8C, 8'h8C, LR_DIVIDER, LR_DIVIDER, 12'h3A2}, '{8'h0A, 8'h0A, LR_BRIDGE, LR_BRIDGE, 12'h000},
        '{8'h3D, 8'h3D, LR_RES_GND, LR_RES_GND, 12'h0C8}, '{8'h00, 8'h00, LR_REMOVE, LR_REMOVE, 12'h000},
        '{8'h2E, 8'h2E, LR_HOLD, LR_HOLD, 12'h000}};
    s3rc_pulldown_type pd_exp [3] = '{PD_KEEP, PD_DROP, PD_HOLD};
    logic [2:0] pd_trig [3] = '{3'h0, 3'h7, 3'h1};
    always #25 sys_clk = ~sys_clk;
    s3rc_bank dut_u (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(rdata), .third_trigger_select(trig),
        .prior_response_present(prior), .legacy_profile_active(legacy), .downstream_plus_line(pl),
        .downstream_minus_line(ml), .plus_reset_pulldown(ppd), .minus_reset_pulldown(mpd),
        .response_level(lvl), .third_pulldown_current(cur), .pulldown_current_valid(cval),
        .third_detect_threshold(thr), .threshold_valid(tval), .third_divider_ratio(ratio));
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        @(negedge sys_clk);
        d = rdata;
    endtask
    // side inputs change at an edge, registered outputs follow one edge later
    task automatic drv(input logic [2:0] t, input logic [1:0] p, input logic l);
        @(posedge sys_clk);
        trig <= t;
        prior <= p;
        legacy <= l;
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #300000;
        fails++;
        test_done;
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h4A, v); chk(v, 8'h00);
        rd(8'h4B, v); chk(v, 8'h00);
        rd(8'h4C, v); chk(v, 8'h00); chk(ratio, 3'h0); chk(cval, 1'b0);
        chk(pl, LR_REMOVE); chk(ml, LR_REMOVE); chk(ppd, PD_HOLD); chk(lvl, 12'h000);
        chk(cur, 8'h0A); chk(thr, 12'h190); chk(tval, 1'b1);
        foreach (rows[i]) begin
            wr(8'h4A, rows[i].wd);
            rd(8'h4A, v);
            chk(v, rows[i].rd);
            chk(pl, rows[i].p);
            chk(ml, rows[i].m);
            chk(lvl, rows[i].lv);
        end
        @(negedge sys_clk); chk(rdata, 8'h00);
        wr(8'h4B, 8'hFF); rd(8'h4B, v); chk(v, 8'h30);
        chk(cur, 8'h96);
        wr(8'h4B, 8'h23); rd(8'h4B, v); chk(v, 8'h23);
        chk(thr, 12'h12C); chk(tval, 1'b1);
        wr(8'h4A, 8'h01); rd(8'h4A, v); chk(v, 8'h01); chk(cval, 1'b1);
        chk(cur, 8'h64);
        drv(3'h1, 2'h0, 1'b1); wr(8'h4B, 8'h05); rd(8'h4B, v); chk(v, 8'h05);
        chk(thr, 12'h12C); chk(tval, 1'b0); chk(cval, 1'b0);
        drv(3'h0, 2'h0, 1'b0); chk(tval, 1'b0); chk(thr, 12'h1F4);
        chk(ppd, PD_KEEP);
        drv(3'h7, 2'h0, 1'b0); chk(tval, 1'b0);
        wr(8'h4C, 8'hFE); rd(8'h4C, v); chk(v, 8'h06); chk(ratio, 3'h6);
        wr(8'h4C, 8'h0F); rd(8'h4C, v); chk(v, 8'h06);
        wr(8'h4D, 8'h55); rd(8'h4D, v); chk(v, 8'h00);
        wr(8'h4A, 8'h0E);
        foreach (pd_trig[i]) begin
            drv(pd_trig[i], 2'h0, 1'b0);
            chk(ppd, pd_exp[i]);
            chk(mpd, pd_exp[i]);
        end
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(8'h4A, v); chk(v, 8'h00); chk(pl, LR_REMOVE);
        rd(8'h4C, v); chk(v, 8'h00); chk(ratio, 3'h0); chk(thr, 12'h190);
        test_done;
    end
endmodule
